// ---- hdl/ext_and_periph_irq_control.sv ----
// Function
// - Each of the three external lines has its own enable bit that lets it interrupt the core.
// - A flag is set whenever its event occurs, whatever its enable or the global enable holds.
// - Flags can always be read so that software may poll them without an interrupt.
// - Peripheral flags are held in three 8-bit flag registers.
// - Three peripheral enable registers gate the matching flag bits one by one.
// - With priority mode off, no peripheral request passes unless the group enable is set.
// - Three peripheral priority registers choose high or low level for each source.
// - Priority bits act only while priority mode is on and are ignored otherwise.
// - The priority mode enable lives in the reset control register.
`timescale 1ns/10ps
`default_nettype none

module ext_and_periph_irq_control
	import irq_ctl_pkg::*;
#(
	parameter int NUM_LINES = EXT_LINES
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	input  wire logic                         we_i,
	input  wire logic [ADR_W-1:0]             adr_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic [WB_DW-1:0]             dat_i,
	output logic      [WB_DW-1:0]             dat_o,
	output logic                              ack_o,
	input  wire logic [NUM_LINES-1:0]         ext_line_i,
	input  wire logic [PERIPH_REGS*REG_W-1:0] periph_event_i,
	output logic                              core_high_req_o,
	output logic                              core_low_req_o,
	output logic                              irq_o
);

	// --------------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------------

	// Byte offset of entry i of a register bank.
	function automatic logic [7:0] bank_off(input logic [7:0] base, input int i);
		bank_off = base + 8'(i * REG_STRIDE);
	endfunction

	// --------------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------------
	logic [REG_W-1:0]    ext_d;
	logic [REG_W-1:0]    ext_q;
	logic [REG_W-1:0]    flag_d [PERIPH_REGS];
	logic [REG_W-1:0]    flag_q [PERIPH_REGS];
	logic [REG_W-1:0]    en_d   [PERIPH_REGS];
	logic [REG_W-1:0]    en_q   [PERIPH_REGS];
	logic [REG_W-1:0]    prio_d [PERIPH_REGS];
	logic [REG_W-1:0]    prio_q [PERIPH_REGS];
	logic [REG_W-1:0]    rctl_d;
	logic [REG_W-1:0]    rctl_q;
	logic [REG_W-1:0]    cctl_d;
	logic [REG_W-1:0]    cctl_q;
	logic [STATUS_W-1:0] status_d;
	logic [STATUS_W-1:0] status_q;
	logic [STATUS_W-1:0] mask_d;
	logic [STATUS_W-1:0] mask_q;
	logic [NUM_LINES-1:0] ext_rise;
	logic                req;
	logic                wr;
	logic                rd;
	logic                ack_d;
	logic                ack_q;
	logic [WB_DW-1:0]    rdata;
	logic [WB_DW-1:0]    dat_q;
	logic [NUM_LINES-1:0] ext_pend;
	logic [NUM_LINES-1:0] ext_prio;
	logic                periph_any;
	logic                periph_hi;
	logic                periph_lo;
	logic                prio_mode;
	logic                global_en;
	logic                group_en;
	logic                high_d;
	logic                high_q;
	logic                low_d;
	logic                low_q;
	logic                irq_d;
	logic                irq_q;

	// --------------------------------------------------------------------
	// External line synchroniser
	// --------------------------------------------------------------------
	pin_edge_sync #(
		.WIDTH (NUM_LINES)
	) u_line_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (ext_line_i),
		.rise_o (ext_rise)
	);

	// --------------------------------------------------------------------
	// Wishbone slave
	// --------------------------------------------------------------------

	// A request is served once; ack drops in the cycle after it was given.
	assign req = cyc_i & stb_i & ~ack_q;
	assign wr  = req & we_i & sel_i[0];
	assign rd  = req & ~we_i;

	// Read mux; unmapped offsets read as zero and accept writes silently.
	always_comb
	begin
		rdata = '0;
		if (adr_i == EXT_CTL_OFF)
			rdata[REG_W-1:0] = ext_q;
		if (adr_i == RESET_CTL_OFF)
			rdata[REG_W-1:0] = rctl_q;
		if (adr_i == CORE_CTL_OFF)
			rdata[REG_W-1:0] = cctl_q;
		if (adr_i == STATUS_OFF)
			rdata[STATUS_W-1:0] = status_q;
		if (adr_i == MASK_OFF)
			rdata[STATUS_W-1:0] = mask_q;
		for (int i = 0; i < PERIPH_REGS; i++)
		begin
			if (adr_i == bank_off(FLAG_BASE_OFF, i))
				rdata[REG_W-1:0] = flag_q[i];
			if (adr_i == bank_off(ENABLE_BASE_OFF, i))
				rdata[REG_W-1:0] = en_q[i];
			if (adr_i == bank_off(PRIO_BASE_OFF, i))
				rdata[REG_W-1:0] = prio_q[i];
		end
		ack_d = req;
	end

	// Ack and read data are registered together.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end
		else
		begin
			ack_q <= ack_d;
			dat_q <= rd ? rdata : dat_q;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// --------------------------------------------------------------------
	// Register file
	// --------------------------------------------------------------------

	// Software writes first, then hardware events OR in so a set wins a clear.
	always_comb
	begin
		ext_d    = ext_q;
		rctl_d   = rctl_q;
		cctl_d   = cctl_q;
		mask_d   = mask_q;
		status_d = status_q;
		flag_d   = flag_q;
		en_d     = en_q;
		prio_d   = prio_q;
		if (wr && adr_i == EXT_CTL_OFF)
			ext_d = dat_i[REG_W-1:0];
		if (wr && adr_i == RESET_CTL_OFF)
			rctl_d = dat_i[REG_W-1:0] & RESET_CTL_MASK;
		if (wr && adr_i == CORE_CTL_OFF)
			cctl_d = dat_i[REG_W-1:0] & CORE_CTL_MASK;
		if (wr && adr_i == MASK_OFF)
			mask_d = dat_i[STATUS_W-1:0];
		for (int i = 0; i < PERIPH_REGS; i++)
		begin
			if (wr && adr_i == bank_off(FLAG_BASE_OFF, i))
				flag_d[i] = dat_i[REG_W-1:0];
			if (wr && adr_i == bank_off(ENABLE_BASE_OFF, i))
				en_d[i] = dat_i[REG_W-1:0];
			if (wr && adr_i == bank_off(PRIO_BASE_OFF, i))
				prio_d[i] = dat_i[REG_W-1:0];
			flag_d[i] = flag_d[i] | periph_event_i[i*REG_W +: REG_W];
		end
		ext_d[EXT_FLAG_LSB +: NUM_LINES] = ext_d[EXT_FLAG_LSB +: NUM_LINES] | ext_rise;
		if (rd && adr_i == STATUS_OFF)
			status_d = STATUS_RESET;
		status_d = status_d | {(|periph_event_i), ext_rise};
	end

	// Registers only; reset values put enables and flags at zero.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_q    <= EXT_CTL_RESET;
			rctl_q   <= RESET_CTL_RESET;
			cctl_q   <= CORE_CTL_RESET;
			status_q <= STATUS_RESET;
			mask_q   <= STATUS_RESET;
			for (int i = 0; i < PERIPH_REGS; i++)
			begin
				flag_q[i] <= PERIPH_RESET;
				en_q[i]   <= PERIPH_RESET;
				prio_q[i] <= PERIPH_RESET;
			end
		end
		else
		begin
			ext_q    <= ext_d;
			rctl_q   <= rctl_d;
			cctl_q   <= cctl_d;
			status_q <= status_d;
			mask_q   <= mask_d;
			flag_q   <= flag_d;
			en_q     <= en_d;
			prio_q   <= prio_d;
		end
	end

	// --------------------------------------------------------------------
	// Request combination
	// --------------------------------------------------------------------

	// Pending terms; a flag counts only while its own enable is set.
	always_comb
	begin
		prio_mode  = rctl_q[PRIO_MODE_BIT];
		global_en  = cctl_q[GLOBAL_EN_BIT];
		group_en   = cctl_q[GROUP_EN_BIT];
		ext_pend   = ext_q[EXT_FLAG_LSB +: NUM_LINES] & ext_q[EXT_EN_LSB +: NUM_LINES];
		ext_prio   = {cctl_q[LINE3_PRIO_BIT], ext_q[EXT_PRIO_TWO], ext_q[EXT_PRIO_ONE]};
		periph_any = 1'b0;
		periph_hi  = 1'b0;
		periph_lo  = 1'b0;
		for (int i = 0; i < PERIPH_REGS; i++)
		begin
			periph_any = periph_any | (|(flag_q[i] & en_q[i]));
			periph_hi  = periph_hi | (|(flag_q[i] & en_q[i] & prio_q[i]));
			periph_lo  = periph_lo | (|(flag_q[i] & en_q[i] & ~prio_q[i]));
		end
		if (prio_mode)
		begin
			// Priority bits steer each source to the high or low request.
			high_d = global_en & ((|(ext_pend & ext_prio)) | periph_hi);
			low_d  = global_en & group_en & ((|(ext_pend & ~ext_prio)) | periph_lo);
		end
		else
		begin
			// Compatible mode: one request level, priority bits ignored.
			high_d = global_en & ((|ext_pend) | (group_en & periph_any));
			low_d  = 1'b0;
		end
		irq_d = |(status_q & mask_q);
	end

	// Request outputs come straight from flip-flops.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			high_q <= 1'b0;
			low_q  <= 1'b0;
			irq_q  <= 1'b0;
		end
		else
		begin
			high_q <= high_d;
			low_q  <= low_d;
			irq_q  <= irq_d;
		end
	end

	assign core_high_req_o = high_q;
	assign core_low_req_o  = low_q;
	assign irq_o           = irq_q;

	// --------------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	line_flag_set_a: assert property (ext_rise[0] |=> ext_q[EXT_FLAG_LSB])
		else $error("line one event did not set its flag");
	periph_flag_set_a: assert property (periph_event_i[0] |=> flag_q[0][0])
		else $error("peripheral event did not set its flag");
	enable_gate_a: assert property ((ext_pend == '0 && !periph_any) |=> !high_q && !low_q)
		else $error("request raised with nothing enabled and pending");
	group_gate_a: assert property ((!prio_mode && !group_en && ext_pend == '0) |=> !high_q)
		else $error("peripheral request passed without group enable");
	prio_ignored_a: assert property (!prio_mode |=> !low_q)
		else $error("low request while priority mode is off");
	high_prio_a: assert property ((prio_mode && global_en && periph_hi) |=> high_q)
		else $error("high priority source did not raise the high request");
	flag_read_a: assert property ((rd && adr_i == EXT_CTL_OFF) |=> ack_o && dat_o[REG_W-1:0] == $past(ext_q))
		else $error("flag register read returned wrong data");
	mode_write_a: assert property ((wr && adr_i == RESET_CTL_OFF) |=> prio_mode == $past(dat_i[PRIO_MODE_BIT]))
		else $error("priority mode bit not written");
	reset_value_a: assert property ($past(rst_i) |-> ext_q == EXT_CTL_RESET && en_q[0] == PERIPH_RESET)
		else $error("wrong reset value");
	flag_sticky_a: assert property ((ext_q[EXT_FLAG_LSB] && !(wr && adr_i == EXT_CTL_OFF)) |=> ext_q[EXT_FLAG_LSB])
		else $error("flag cleared without a software write");

	high_mode_c: cover property (prio_mode ##1 high_q);
	low_mode_c: cover property (prio_mode ##1 low_q);
	status_clear_c: cover property ((rd && adr_i == STATUS_OFF && status_q != '0) ##1 status_q == '0);
	irq_out_c: cover property (!irq_q ##1 irq_q);

endmodule
`default_nettype wire

// ---- hdl/irq_ctl_pkg.sv ----
package irq_ctl_pkg;

	// --------------------------------------------------------------------
	// Bus and register geometry
	// --------------------------------------------------------------------
	localparam int          ADR_W       = 8;
	localparam int          WB_DW       = 32;
	localparam int          REG_W       = 8;
	localparam int          EXT_LINES   = 3;
	localparam int          PERIPH_REGS = 3;
	localparam int          STATUS_W    = 4;
	localparam int          REG_STRIDE  = 4;

	// Byte offsets of the registers.
	localparam logic [7:0]  EXT_CTL_OFF     = 8'h00;
	localparam logic [7:0]  FLAG_BASE_OFF   = 8'h04;
	localparam logic [7:0]  ENABLE_BASE_OFF = 8'h10;
	localparam logic [7:0]  PRIO_BASE_OFF   = 8'h1C;
	localparam logic [7:0]  RESET_CTL_OFF   = 8'h28;
	localparam logic [7:0]  CORE_CTL_OFF    = 8'h2C;
	localparam logic [7:0]  STATUS_OFF      = 8'h30;
	localparam logic [7:0]  MASK_OFF        = 8'h34;

	// Field positions of the external line control register.
	localparam int          EXT_PRIO_TWO    = 7;
	localparam int          EXT_PRIO_ONE    = 6;
	localparam int          EXT_EN_LSB      = 3;
	localparam int          EXT_FLAG_LSB    = 0;

	// Field positions of the reset control and core control registers.
	localparam int          PRIO_MODE_BIT   = 7;
	localparam int          GLOBAL_EN_BIT   = 7;
	localparam int          GROUP_EN_BIT    = 6;
	localparam int          LINE3_PRIO_BIT  = 0;

	// Reset values and writable masks.
	localparam logic [7:0]  EXT_CTL_RESET   = 8'hC0;
	localparam logic [7:0]  PERIPH_RESET    = 8'h00;
	localparam logic [7:0]  RESET_CTL_RESET = 8'h00;
	localparam logic [7:0]  RESET_CTL_MASK  = 8'h80;
	localparam logic [7:0]  CORE_CTL_RESET  = 8'h01;
	localparam logic [7:0]  CORE_CTL_MASK   = 8'hC1;
	localparam logic [3:0]  STATUS_RESET    = 4'h0;

endpackage

// ---- hdl/pin_edge_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module pin_edge_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] rise_o
);

	// --------------------------------------------------------------------
	// Two-stage synchroniser and rising edge detector
	// --------------------------------------------------------------------
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] last_q;
	logic [WIDTH-1:0] rise_d;
	logic [WIDTH-1:0] rise_q;

	// The edge is seen only between the second and third stages.
	always_comb
	begin
		rise_d = sync_q & ~last_q;
	end

	// Stage one feeds stage two and nothing else.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
			rise_q <= '0;
		end
		else
		begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			last_q <= sync_q;
			rise_q <= rise_d;
		end
	end

	assign rise_o = rise_q;

endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import irq_ctl_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and the unit under test
	// ----------------------------------------------------------------
	logic                         clk_i;
	logic                         rst_i;
	logic                         cyc_i;
	logic                         stb_i;
	logic                         we_i;
	logic [ADR_W-1:0]             adr_i;
	logic [3:0]                   sel_i;
	logic [WB_DW-1:0]             dat_i;
	logic [WB_DW-1:0]             dat_o;
	logic                         ack_o;
	logic [EXT_LINES-1:0]         ext_line_i;
	logic [PERIPH_REGS*REG_W-1:0] periph_event_i;
	logic                         core_high_req_o;
	logic                         core_low_req_o;
	logic                         irq_o;
	int                           failures;
	int                           checks;
	logic [WB_DW-1:0]             rd;

	ext_and_periph_irq_control #(.NUM_LINES(EXT_LINES)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.ext_line_i(ext_line_i), .periph_event_i(periph_event_i),
		.core_high_req_o(core_high_req_o), .core_low_req_o(core_low_req_o),
		.irq_o(irq_o)
	);

	// The clock toggles every half period of 12.5 ns.
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Prints the counts and the verdict, then stops the run.
	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One classic cycle; the request is held until ack is sampled high.
	task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= {24'h00_0000, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			failures++;
			summarize();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb_cycle(1'b1, a, d, 4'h1);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		wb_cycle(1'b0, a, 8'h00, 4'hF);
		check(name, rd, {24'h00_0000, exp});
	endtask

	// Lets registered request outputs follow a register change.
	task automatic settle();
		repeat (3) @(posedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		failures = 0;
		checks = 0;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0000_0000;
		ext_line_i = 3'b000;
		periph_event_i = 24'h00_0000;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values of every register but the mask, and an unmapped place.
		rd_chk("ext_ctl", EXT_CTL_OFF, 8'hC0);
		for (int i = 0; i < 3; i++)
		begin
			rd_chk("flag", FLAG_BASE_OFF + 8'(4*i), 8'h00);
			rd_chk("enable", ENABLE_BASE_OFF + 8'(4*i), 8'h00);
			rd_chk("prio", PRIO_BASE_OFF + 8'(4*i), 8'h00);
		end
		rd_chk("reset_ctl", RESET_CTL_OFF, 8'h00);
		rd_chk("core_ctl", CORE_CTL_OFF, 8'h01);
		rd_chk("status", STATUS_OFF, 8'h00);
		rd_chk("unmapped", 8'h3C, 8'h00);
		// A write without byte lane zero is ignored.
		wr(MASK_OFF, 8'h01);
		wb_cycle(1'b1, MASK_OFF, 8'h0F, 4'h2);
		rd_chk("mask", MASK_OFF, 8'h01);
		// Pin events latch flags while every line and core enable is off.
		ext_line_i <= 3'b111;
		repeat (8) @(posedge clk_i);
		ext_line_i <= 3'b000;
		check("irq", irq_o, 1'b1);
		check("high_req", core_high_req_o, 1'b0);
		rd_chk("ext_ctl", EXT_CTL_OFF, 8'hC7);
		rd_chk("status", STATUS_OFF, 8'h07);
		settle();
		check("irq", irq_o, 1'b0);
		rd_chk("status", STATUS_OFF, 8'h00);
		// Line one enabled: request rises; flags are not cleared by hardware.
		wr(CORE_CTL_OFF, 8'h81);
		settle();
		check("high_req", core_high_req_o, 1'b0);
		wr(EXT_CTL_OFF, 8'hC0);
		wr(EXT_CTL_OFF, 8'hC8);
		settle();
		check("high_req", core_high_req_o, 1'b0);
		ext_line_i <= 3'b001;
		repeat (8) @(posedge clk_i);
		ext_line_i <= 3'b000;
		settle();
		check("high_req", core_high_req_o, 1'b1);
		repeat (10) @(posedge clk_i);
		rd_chk("ext_ctl", EXT_CTL_OFF, 8'hC9);
		wr(EXT_CTL_OFF, 8'h08);
		settle();
		check("high_req", core_high_req_o, 1'b0);
		rd_chk("ext_ctl", EXT_CTL_OFF, 8'h08);
		// Peripheral event in flag register b, bit one.
		periph_event_i <= 24'h00_0200;
		@(posedge clk_i);
		periph_event_i <= 24'h00_0000;
		settle();
		rd_chk("flag_b", FLAG_BASE_OFF + 8'h04, 8'h02);
		rd_chk("flag_a", FLAG_BASE_OFF, 8'h00);
		rd_chk("status", STATUS_OFF, 8'h09);
		// The flag is cleared before its source is enabled, then raised again.
		wr(FLAG_BASE_OFF + 8'h04, 8'h00);
		wr(ENABLE_BASE_OFF + 8'h04, 8'h02);
		periph_event_i <= 24'h00_0200;
		@(posedge clk_i);
		periph_event_i <= 24'h00_0000;
		settle();
		check("high_req", core_high_req_o, 1'b0);
		wr(CORE_CTL_OFF, 8'hC1);
		settle();
		check("high_req", core_high_req_o, 1'b1);
		check("low_req", core_low_req_o, 1'b0);
		// Priority mode on: the source's priority bit picks the level.
		wr(RESET_CTL_OFF, 8'hFF);
		rd_chk("reset_ctl", RESET_CTL_OFF, 8'h80);
		settle();
		check("high_req", core_high_req_o, 1'b0);
		check("low_req", core_low_req_o, 1'b1);
		wr(PRIO_BASE_OFF + 8'h04, 8'h02);
		settle();
		check("high_req", core_high_req_o, 1'b1);
		check("low_req", core_low_req_o, 1'b0);
		// Priority mode off again: a low priority bit is ignored.
		wr(PRIO_BASE_OFF + 8'h04, 8'h00);
		wr(RESET_CTL_OFF, 8'h00);
		settle();
		check("high_req", core_high_req_o, 1'b1);
		check("low_req", core_low_req_o, 1'b0);
		// Disabling the source gates its pending flag.
		wr(ENABLE_BASE_OFF + 8'h04, 8'h00);
		settle();
		check("high_req", core_high_req_o, 1'b0);
		rd_chk("flag_b", FLAG_BASE_OFF + 8'h04, 8'h02);
		// Priority mode with line one: its own priority bit picks the level.
		wr(RESET_CTL_OFF, 8'h80);
		wr(EXT_CTL_OFF, 8'h88);
		ext_line_i <= 3'b001;
		repeat (8) @(posedge clk_i);
		ext_line_i <= 3'b000;
		check("low_req", core_low_req_o, 1'b1);
		check("high_req", core_high_req_o, 1'b0);
		wr(EXT_CTL_OFF, 8'hC9);
		settle();
		check("high_req", core_high_req_o, 1'b1);
		check("low_req", core_low_req_o, 1'b0);
		summarize();
	end
endmodule

`default_nettype wire
